// ==== ptq_checker.sv ====
// checker on the qualifier ports: apb answer timing and trigger shape
// assumes one clock domain, asynchronous active-high reset
module ptq_checker (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// apb
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	// trigger
	input wire trig_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// trigger shape and quiet start
	property p_trig_one; trig_pulse |=> !trig_pulse; endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger held");
	property p_rst_quiet; $past(rst) |-> !trig_pulse && !pready; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
	// one wait state, answer lasts a cycle
	property p_ready_wait; psel && !penable |=> !pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("answer early");
	property p_ready_due; psel && penable && !pready |=> pready; endproperty
	a_ready_due: assert property (p_ready_due) else $error("answer late");
	property p_ready_one; pready |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("answer held");
	property p_ready_cause; pready |-> $past(psel && penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("answer unasked");
	// error only on unmapped words
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error alone");
	property p_err_bad; psel && penable && !pready && paddr > 12'h01c |=> pslverr; endproperty
	a_err_bad: assert property (p_err_bad) else $error("no error");
	property p_err_good;
		psel && penable && !pready && paddr < 12'h020 && paddr[1:0] == 2'h0 |=> !pslverr;
	endproperty
	a_err_good: assert property (p_err_good) else $error("false error");
endmodule // ptq_checker

bind ptq_qualifier ptq_checker chk (.core_clk(core_clk), .rst(rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.trig_pulse(trig_pulse));

// ==== ptq_cmp_model.sv ====
// comparator model: one channel follows an amplitude step, others toggle
// assumes amp and ch change just after a rising edge
module ptq_cmp_model (
	// clock
	input wire logic core_clk,
	// amplitude 0..3 and its channel
	input wire logic [1:0] amp,
	input wire logic [1:0] ch,
	// comparator levels
	output logic [3:0] cmp_level,
	output logic [3:0] cmp_lower,
	output logic [3:0] cmp_upper
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	// idle channels toggle so a wrong source select fires often
	always @(posedge core_clk) begin
		tog <= ~tog;
		for (int i = 0; i < 4; i++) begin
			cmp_lower[i] <= (i == ch) ? amp >= 2'h1 : tog;
			cmp_level[i] <= (i == ch) ? amp >= 2'h2 : tog;
			cmp_upper[i] <= (i == ch) ? amp == 2'h3 : tog;
		end
	end
endmodule // ptq_cmp_model

// ==== ptq_map.vh ====
// register map, field layout, codes and reset values of the pulse trigger qualifier
// assumes a 32-bit apb slave where each register takes one aligned word
`ifndef PTQ_MAP_VH
`define PTQ_MAP_VH

// register byte offsets
`define PTQ_OFF_CTRL 12'h000
`define PTQ_OFF_GLITCH 12'h004
`define PTQ_OFF_WLO 12'h008
`define PTQ_OFF_WHI 12'h00c
`define PTQ_OFF_SLEW 12'h010
`define PTQ_OFF_TOUT 12'h014
`define PTQ_OFF_RUNTW 12'h018
`define PTQ_OFF_STAT 12'h01c

// control register fields
`define PTQ_CLS_MSB 2
`define PTQ_CLS_LSB 0
`define PTQ_POL_MSB 5
`define PTQ_POL_LSB 4
`define PTQ_OPT_BIT 8
`define PTQ_SRC_MSB 13
`define PTQ_SRC_LSB 12
`define PTQ_CTRL_W 14

// status register fields
`define PTQ_ST_LVL_BIT 16
`define PTQ_ST_LO_BIT 17
`define PTQ_ST_HI_BIT 18
`define PTQ_ST_SEQ_MSB 21
`define PTQ_ST_SEQ_LSB 20

// pulse classes
`define PTQ_CLS_GLITCH 3'h0
`define PTQ_CLS_RUNT 3'h1
`define PTQ_CLS_WIDTH 3'h2
`define PTQ_CLS_SLEW 3'h3
`define PTQ_CLS_TOUT 3'h4

// polarity / timeout side
`define PTQ_POL_POS 2'h0
`define PTQ_POL_NEG 2'h1
`define PTQ_POL_EITHER 2'h2

// reset values
`define PTQ_RST_CTRL 14'h0000
`define PTQ_RST_LIMIT 16'h0010
`define PTQ_RST_WHI 16'h0020

`endif

// ==== ptq_qualifier.v ====
// pulse trigger qualifier: glitch, runt, width, slew and timeout classes on one source
// assumes comparator inputs already synchronous to core_clk, apb master on the same clock
//
// The APB slave port and the register addresses are this design's own decisions.
`include "ptq_map.vh"

// Operation
// - glitch positive: short high pulse fires
// - glitch negative: short low pulse fires
// - glitch either: short pulse of any polarity
// - reject option fires on wider pulses only
// - positive runt: lower crossed, upper never
// - negative runt: upper crossed, lower never
// - either runt: whichever threshold crossed first
// - runt fires on recrossing first threshold
// - runt fires always or only if wider
// - width inside limits, or outside if chosen
// - width polarity picks high or low pulse
// - positive slew: lower to upper timed
// - negative slew: upper to lower timed
// - either slew: any edge both thresholds
// - slew fires faster or slower than limit
// - timeout high: stays above level too long
// - timeout low: stays below level too long
// - timeout either: stays on one side
// - five classes, one active at once
// - one source select for every class
module ptq_qualifier #(
	parameter NCH = 4,
	parameter CW = 16
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// comparator outputs, one bit per channel
	input wire [NCH-1:0] cmp_level,
	input wire [NCH-1:0] cmp_lower,
	input wire [NCH-1:0] cmp_upper,
	// qualified trigger
	output reg trig_pulse
);

	// crossing sequence states shared by runt and slew
	localparam SEQ_IDLE = 2'h0;
	localparam SEQ_UP = 2'h1;
	localparam SEQ_DN = 2'h2;
	localparam [CW-1:0] CNT_MAX = {CW{1'b1}};

	// saturating increment, shared by both counters
	// saturation keeps a very long pulse from looking short after a wrap
	function [CW-1:0] sat_inc;
		input [CW-1:0] v;
		begin
			sat_inc = (v == CNT_MAX) ? v : v + {{(CW-1){1'b0}}, 1'b1};
		end
	endfunction

	// address decode, used for writes and the error answer; the read mux decodes paddr itself
	function is_mapped;
		input [11:0] a;
		begin
			case (a)
				`PTQ_OFF_CTRL, `PTQ_OFF_GLITCH, `PTQ_OFF_WLO, `PTQ_OFF_WHI,
				`PTQ_OFF_SLEW, `PTQ_OFF_TOUT, `PTQ_OFF_RUNTW, `PTQ_OFF_STAT: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// configuration
	reg [`PTQ_CTRL_W-1:0] ctrl_q;
	reg [CW-1:0] glitch_q;
	reg [CW-1:0] wlo_q;
	reg [CW-1:0] whi_q;
	reg [CW-1:0] slew_q;
	reg [CW-1:0] tout_q;
	reg [CW-1:0] runtw_q;
	reg [15:0] count_q;
	reg clr_q;

	wire [2:0] cls = ctrl_q[`PTQ_CLS_MSB:`PTQ_CLS_LSB];
	wire [1:0] pol = ctrl_q[`PTQ_POL_MSB:`PTQ_POL_LSB];
	wire opt = ctrl_q[`PTQ_OPT_BIT];
	wire [`PTQ_SRC_MSB-`PTQ_SRC_LSB:0] src = ctrl_q[`PTQ_SRC_MSB:`PTQ_SRC_LSB];
	// polarity 3 behaves as either
	wire pol_up = (pol != `PTQ_POL_NEG);
	wire pol_dn = (pol != `PTQ_POL_POS);

	// sampled source and previous samples
	reg s_lvl_q, s_lo_q, s_hi_q;
	reg p_lvl_q, p_lo_q, p_hi_q;
	reg [CW-1:0] cnt_q;
	reg have_q;
	reg tdone_q;
	reg [1:0] seq_q;
	reg [CW-1:0] scnt_q;

	// apb access phase commits on the edge where pready is seen high
	wire acc = psel & penable & pready;
	wire wr_ok = acc & pwrite & is_mapped(paddr);

	// apb: one wait state, answer registered
	// the wait state keeps the read mux off the request path
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			pslverr <= ~is_mapped(paddr);
			prdata <= 32'h0000_0000;
			if (~pwrite) begin
				case (paddr)
					`PTQ_OFF_CTRL: prdata <= {{(32-`PTQ_CTRL_W){1'b0}}, ctrl_q};
					`PTQ_OFF_GLITCH: prdata <= {{(32-CW){1'b0}}, glitch_q};
					`PTQ_OFF_WLO: prdata <= {{(32-CW){1'b0}}, wlo_q};
					`PTQ_OFF_WHI: prdata <= {{(32-CW){1'b0}}, whi_q};
					`PTQ_OFF_SLEW: prdata <= {{(32-CW){1'b0}}, slew_q};
					`PTQ_OFF_TOUT: prdata <= {{(32-CW){1'b0}}, tout_q};
					`PTQ_OFF_RUNTW: prdata <= {{(32-CW){1'b0}}, runtw_q};
					`PTQ_OFF_STAT: begin
						prdata <= 32'h0000_0000;
						prdata[15:0] <= count_q;
						prdata[`PTQ_ST_LVL_BIT] <= s_lvl_q;
						prdata[`PTQ_ST_LO_BIT] <= s_lo_q;
						prdata[`PTQ_ST_HI_BIT] <= s_hi_q;
						prdata[`PTQ_ST_SEQ_MSB:`PTQ_ST_SEQ_LSB] <= seq_q;
					end
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end else begin
			// answer lasts one cycle, so a held request is not answered twice
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// configuration writes; any of them restarts the measurements next cycle
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `PTQ_RST_CTRL;
			glitch_q <= `PTQ_RST_LIMIT;
			wlo_q <= `PTQ_RST_LIMIT;
			whi_q <= `PTQ_RST_WHI;
			slew_q <= `PTQ_RST_LIMIT;
			tout_q <= `PTQ_RST_LIMIT;
			runtw_q <= `PTQ_RST_LIMIT;
			clr_q <= 1'b1;
		end else begin
			// status writes are dropped and do not restart detection
			clr_q <= wr_ok & (paddr != `PTQ_OFF_STAT);
			if (wr_ok) begin
				case (paddr)
					`PTQ_OFF_CTRL: ctrl_q <= pwdata[`PTQ_CTRL_W-1:0];
					`PTQ_OFF_GLITCH: glitch_q <= pwdata[CW-1:0];
					`PTQ_OFF_WLO: wlo_q <= pwdata[CW-1:0];
					`PTQ_OFF_WHI: whi_q <= pwdata[CW-1:0];
					`PTQ_OFF_SLEW: slew_q <= pwdata[CW-1:0];
					`PTQ_OFF_TOUT: tout_q <= pwdata[CW-1:0];
					`PTQ_OFF_RUNTW: runtw_q <= pwdata[CW-1:0];
					default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// source sample: one channel feeds every class
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_lvl_q <= 1'b0;
			s_lo_q <= 1'b0;
			s_hi_q <= 1'b0;
			p_lvl_q <= 1'b0;
			p_lo_q <= 1'b0;
			p_hi_q <= 1'b0;
		end else begin
			s_lvl_q <= cmp_level[src];
			s_lo_q <= cmp_lower[src];
			s_hi_q <= cmp_upper[src];
			p_lvl_q <= s_lvl_q;
			p_lo_q <= s_lo_q;
			p_hi_q <= s_hi_q;
		end
	end

	// edges of the sampled source, one cycle after the comparator moved
	wire lvl_chg = s_lvl_q ^ p_lvl_q;
	wire lvl_rise = s_lvl_q & ~p_lvl_q;
	wire lvl_fall = ~s_lvl_q & p_lvl_q;
	wire lo_rise = s_lo_q & ~p_lo_q;
	wire lo_fall = ~s_lo_q & p_lo_q;
	wire hi_rise = s_hi_q & ~p_hi_q;
	wire hi_fall = ~s_hi_q & p_hi_q;

	// timeout: fires once per stretch, when it passes the limit
	wire to_side = s_lvl_q ? pol_up : pol_dn;
	// the top count never fires, so a saturated count cannot retrigger
	wire to_hit = ~lvl_chg & ~tdone_q & to_side & (cnt_q == tout_q) & (cnt_q != CNT_MAX);

	// level pulse duration, held cycles of the level that just ended
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= {CW{1'b0}};
			have_q <= 1'b0;
			tdone_q <= 1'b0;
		end else if (clr_q) begin
			cnt_q <= {CW{1'b0}};
			have_q <= 1'b0;
			tdone_q <= 1'b0;
		end else if (lvl_chg) begin
			cnt_q <= {{(CW-1){1'b0}}, 1'b1};
			have_q <= 1'b1;
			tdone_q <= 1'b0;
		end else begin
			cnt_q <= sat_inc(cnt_q);
			if (to_hit)
				tdone_q <= 1'b1;
		end
	end

	// glitch: the pulse that ends decides polarity; a partial first pulse is ignored
	wire end_pos = lvl_fall & have_q;
	wire end_neg = lvl_rise & have_q;
	wire g_pol = (end_pos & pol_up) | (end_neg & pol_dn);
	// reject turns the narrower test into a wider one
	wire g_wid = opt ? (cnt_q > glitch_q) : (cnt_q < glitch_q);
	wire g_fire = g_pol & g_wid;

	// width: positive polarity measures high pulses, negative low pulses
	wire w_pol = (pol == `PTQ_POL_NEG) ? end_neg : end_pos;
	wire w_in = (cnt_q >= wlo_q) & (cnt_q <= whi_q);
	wire w_fire = w_pol & (opt ? ~w_in : w_in);

	// runt and slew share one crossing sequence; class picks complete or abort
	reg [1:0] seq_d;
	reg [CW-1:0] scnt_d;
	reg seq_fire;
	wire seq_cls = (cls == `PTQ_CLS_RUNT) | (cls == `PTQ_CLS_SLEW);
	wire is_runt = (cls == `PTQ_CLS_RUNT);
	wire runt_ok = ~opt | (scnt_q > runtw_q);
	wire slew_ok = opt ? (scnt_q > slew_q) : (scnt_q < slew_q);

	always @* begin
		seq_d = seq_q;
		scnt_d = sat_inc(scnt_q);
		seq_fire = 1'b0;
		case (seq_q)
			SEQ_IDLE: begin
				scnt_d = {{(CW-1){1'b0}}, 1'b1};
				if (seq_cls & lo_rise & ~s_hi_q & pol_up)
					seq_d = SEQ_UP;
				else if (seq_cls & hi_fall & s_lo_q & pol_dn)
					seq_d = SEQ_DN;
			end
			SEQ_UP: begin
				if (is_runt) begin
					if (hi_rise)
						seq_d = SEQ_IDLE;
					else if (lo_fall) begin
						seq_d = SEQ_IDLE;
						seq_fire = runt_ok;
					end
				end else begin
					if (hi_rise) begin
						seq_d = SEQ_IDLE;
						seq_fire = slew_ok;
					end else if (lo_fall)
						seq_d = SEQ_IDLE;
				end
			end
			SEQ_DN: begin
				if (is_runt) begin
					if (lo_fall)
						seq_d = SEQ_IDLE;
					else if (hi_rise) begin
						seq_d = SEQ_IDLE;
						seq_fire = runt_ok;
					end
				end else begin
					if (lo_fall) begin
						seq_d = SEQ_IDLE;
						seq_fire = slew_ok;
					end else if (hi_rise)
						seq_d = SEQ_IDLE;
				end
			end
			default: seq_d = SEQ_IDLE;
		endcase
	end

	// sequence state; a config write drops any armed crossing
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seq_q <= SEQ_IDLE;
			scnt_q <= {CW{1'b0}};
		end else if (clr_q | ~seq_cls) begin
			seq_q <= SEQ_IDLE;
			scnt_q <= {CW{1'b0}};
		end else begin
			seq_q <= seq_d;
			scnt_q <= scnt_d;
		end
	end

	// class select: at most one detector reaches the trigger, none for class codes 5 to 7
	reg fire;
	always @* begin
		case (cls)
			`PTQ_CLS_GLITCH: fire = g_fire;
			`PTQ_CLS_RUNT: fire = seq_fire;
			`PTQ_CLS_WIDTH: fire = w_fire;
			`PTQ_CLS_SLEW: fire = seq_fire;
			`PTQ_CLS_TOUT: fire = to_hit;
			default: fire = 1'b0;
		endcase
	end

	// registered one-cycle trigger, plus a wrapping event count for software
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trig_pulse <= 1'b0;
			count_q <= 16'h0000;
		end else begin
			trig_pulse <= fire & ~clr_q;
			if (fire & ~clr_q)
				count_q <= count_q + 16'h0001;
		end
	end

endmodule // ptq_qualifier

// ==== ptq_qualifier_test.sv ====
// self-checking bench for the pulse trigger qualifier
// assumes the comparator model and the bound checker
module ptq_qualifier_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic trig_pulse;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [1:0] amp = '0, ch = '0;
	logic [3:0] cmp_level, cmp_lower, cmp_upper;
	int errors = 0, checked = 0, trig_cnt = 0;
	ptq_qualifier dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_level(cmp_level), .cmp_lower(cmp_lower),
		.cmp_upper(cmp_upper), .trig_pulse(trig_pulse));
	ptq_cmp_model model (.core_clk(core_clk), .amp(amp), .ch(ch), .cmp_level(cmp_level),
		.cmp_lower(cmp_lower), .cmp_upper(cmp_upper));
	// 8 ns clock
	always #4 core_clk = ~core_clk;
	// tally trigger pulses
	always @(posedge core_clk) if (trig_pulse === 1'b1) trig_cnt <= trig_cnt + 1;
	task check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one apb transfer, bounded wait for pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge core_clk);
		if (pready !== 1'b1) begin
			errors++;
			give_verdict;
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// configure, settle, then one level step of n1 samples; count triggers
	task run(input [15:0] c, input [1:0] a0, a1, input [7:0] n1, input [1:0] a2, input int e);
		int t;
		amp <= a0;
		apb(1, 12'h000, {16'h0, c});
		repeat (40) @(posedge core_clk);
		t = trig_cnt;
		amp <= a1;
		repeat (n1) @(posedge core_clk);
		amp <= a2;
		repeat (20) @(posedge core_clk);
		check("trigger count", trig_cnt - t, e);
	endtask
	task s_regs;
		apb(0, 12'h004, '0);
		check("glitch limit", rd, 32'h10);
		apb(0, 12'h00c, '0);
		check("upper width", rd, 32'h20);
		apb(0, 12'h100, '0);
		check("unmapped error", err, 1'b1);
		apb(1, 12'h004, 32'h4);
		apb(0, 12'h004, '0);
		check("glitch limit", rd, 32'h4);
	endtask
	task s_glitch;
		run(16'h0000, 0, 2, 2, 0, 1);
		run(16'h0000, 0, 2, 5, 0, 0);
		run(16'h0010, 2, 0, 2, 2, 1);
		run(16'h0020, 2, 0, 2, 2, 1);
		run(16'h0100, 0, 2, 5, 0, 1);
		run(16'h0100, 0, 2, 2, 0, 0);
		run(16'h0110, 2, 0, 5, 2, 1);
	endtask
	task s_runt;
		run(16'h0001, 0, 2, 5, 0, 1);
		run(16'h0001, 0, 3, 5, 0, 0);
		run(16'h0011, 3, 1, 5, 3, 1);
		run(16'h0021, 3, 1, 5, 3, 1);
		run(16'h0101, 0, 2, 5, 0, 0);
		run(16'h0101, 0, 2, 30, 0, 1);
	endtask
	task s_width;
		run(16'h0002, 0, 2, 20, 0, 1);
		run(16'h0002, 0, 2, 5, 0, 0);
		run(16'h0102, 0, 2, 5, 0, 1);
		run(16'h0012, 2, 0, 20, 2, 1);
	endtask
	task s_slew;
		run(16'h0003, 0, 1, 5, 3, 1);
		run(16'h0103, 0, 1, 30, 3, 1);
		run(16'h0013, 3, 1, 5, 0, 1);
		run(16'h0023, 0, 1, 5, 3, 1);
	endtask
	task s_tout;
		run(16'h0004, 0, 2, 30, 2, 1);
		run(16'h0014, 2, 0, 30, 0, 1);
		run(16'h0024, 0, 2, 30, 2, 1);
		run(16'h0005, 0, 2, 2, 0, 0);
	endtask
	task s_source;
		ch <= 2'h2;
		run(16'h2000, 0, 2, 2, 0, 1);
		run(16'h2002, 0, 2, 20, 0, 1);
	endtask
	task s_reset;
		apb(0, 12'h01c, '0);
		check("status count", rd, trig_cnt);
		ch <= 2'h0;
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		apb(0, 12'h000, '0);
		check("control after reset", rd, 32'h0);
		apb(0, 12'h004, '0);
		check("glitch limit after reset", rd, 32'h10);
		apb(0, 12'h01c, '0);
		check("status after reset", rd, 32'h0);
	endtask
	// reset for ten cycles, then the scenarios
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		s_regs;
		s_glitch;
		s_runt;
		s_width;
		s_slew;
		s_tout;
		s_source;
		s_reset;
		give_verdict;
	end
endmodule // ptq_qualifier_test
